//--- hw/bce_pkg.sv
/*
 Constants, encodings and the state codes of the branch and control executor.
 Assumes the core decodes instructions into bce_op_e codes ahead of this block.
*/
// How it works
// - Every branch kind except table branches redirects to a label target or the source register value.
// - Linked branches write the following instruction address into register 14; a switching call writes the marker.
// - The value written to the link register has bit 0 set, except the return marker.
// - Register branches fault when source register bit 0 is zero.
// - Register branches copy bit 0 into the thumb bit and clear it from target.
// - Label reach: plain 2KB, conditional -256..+254, linked 16MB; else fault.
// - Conditional plain branch alone carries its own condition; larger reach inside a block.
// - No instruction of this group writes the condition flags.
// - Non-secure register branches switch state when source bit 0 is zero.
// - Switching linked form pushes return address and status, loads return marker.
// - Non-secure branches executed in non-secure state fault as undefined.
// - Compare branches test the operand against zero, flags untouched.
// - Compare branches take registers 0 to 7 only, target 4 to 130 bytes ahead.
// - Block prefix conditions up to four instructions by then or else switches.
// - A breakpoint inside a block executes even when its condition fails.
// - Exceptions may split a block; the block state is saved and restored.
// - Byte table branch offset is the unsigned byte at base plus index.
// - Halfword table shifts index by one; offset is twice the halfword.
// - Table target is the following instruction plus offset; PC base is that address.
package bce_pkg;
    typedef enum logic [3:0] {
        OP_OTHER = 4'h0, OP_B = 4'h1, OP_B_COND = 4'h2, OP_BL = 4'h3,
        OP_REG_BR = 4'h4, OP_REG_BR_LINK = 4'h5, OP_NS_BR = 4'h6, OP_NS_BR_LINK = 4'h7,
        OP_CB_ZERO = 4'h8, OP_CB_NONZERO = 4'h9, OP_IT = 4'ha, OP_TB_BYTE = 4'hb,
        OP_TB_HALF = 4'hc, OP_BREAKPOINT_INSTRUCTION = 4'hd, OP_IRQ_MASK = 4'he
    } bce_op_e;
    typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_TBL = 2'b10} bce_state_e;
    localparam logic [3:0] COND_AL = 4'he;
    localparam logic [3:0] LINK_REG_IDX = 4'he;
    localparam logic [3:0] LOW_REG_MAX = 4'h7;
    localparam logic [1:0] IT_MAX_LEN = 2'h3;
    localparam logic [31:0] PC_AHEAD = 32'h0000_0004;
    localparam logic [31:0] NARROW_LEN = 32'h0000_0002;
    localparam logic [31:0] WIDE_LEN = 32'h0000_0004;
    localparam logic signed [31:0] B_MIN = -32'sd2048;
    localparam logic signed [31:0] B_MAX = 32'sd2048;
    localparam logic signed [31:0] BC_MIN = -32'sd256;
    localparam logic signed [31:0] BC_MAX = 32'sd254;
    localparam logic signed [31:0] BL_MIN = -32'sd16777216;
    localparam logic signed [31:0] BL_MAX = 32'sd16777216;
    localparam logic signed [31:0] CB_MIN = 32'sd4;
    localparam logic signed [31:0] CB_MAX = 32'sd130;
    localparam int IT_SAVE_W = 11;
endpackage

//--- hw/bce_cond.sv
/*
 Condition code evaluator for the four status flags.
 Assumes flags arrive as n, z, c, v in bits 3 down to 0.
*/
`timescale 1ns/100ps
module bce_cond (
    input wire logic [3:0] cond,
    input wire logic [3:0] flags,
    output logic pass
);
    logic n, z, c, v, base;
    always_comb begin
        n = flags[3];
        z = flags[2];
        c = flags[1];
        v = flags[0];
        case (cond[3:1])
            3'h0: base = z;
            3'h1: base = c;
            3'h2: base = n;
            3'h3: base = v;
            3'h4: base = c & ~z;
            3'h5: base = (n == v);
            3'h6: base = ~z & (n == v);
            default: base = 1'b1;
        endcase
        // Odd codes invert, except the always pair
        if (cond[3:1] == 3'h7) begin
            pass = 1'b1;
        end else begin
            pass = base ^ cond[0];
        end
    end
endmodule

//--- hw/bce_itstate.sv
/*
 Conditional block tracker: base condition, switches and count left.
 Assumes the executor steps it once per instruction taken inside a block.
*/
`timescale 1ns/100ps
module bce_itstate (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic start,
    input wire logic [3:0] start_cond,
    input wire logic [2:0] start_sw,
    input wire logic [1:0] start_len,
    input wire logic step,
    input wire logic exc_take,
    input wire logic exc_return,
    input wire logic [bce_pkg::IT_SAVE_W-1:0] restore_val,
    output logic active,
    output logic last,
    output logic [3:0] cur_cond,
    output logic [bce_pkg::IT_SAVE_W-1:0] save_val
);
    typedef struct packed {
        logic active;
        logic [3:0] cond;
        logic els;
        logic [2:0] sw;
        logic [1:0] left;
    } bce_it_s;
    bce_it_s s_ff, nxt_s;
    always_comb begin
        nxt_s = s_ff;
        if (exc_take) begin
            nxt_s = '0;
        end else if (exc_return) begin
            nxt_s = restore_val;
        end else if (start) begin
            nxt_s.active = 1'b1;
            nxt_s.cond = start_cond;
            nxt_s.els = 1'b0;
            nxt_s.sw = start_sw;
            nxt_s.left = start_len;
        end else if (step && s_ff.active) begin
            nxt_s.active = (s_ff.left != 2'h0);
            nxt_s.els = s_ff.sw[2];
            nxt_s.sw = {s_ff.sw[1:0], 1'b0};
            nxt_s.left = s_ff.left - 2'h1;
        end
    end
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end
    assign active = s_ff.active;
    assign last = s_ff.active && (s_ff.left == 2'h0);
    assign cur_cond = {s_ff.cond[3:1], s_ff.cond[0] ^ s_ff.els};
    assign save_val = s_ff;
endmodule

//--- hw/bce_exec.sv
/*
 Branch and control executor: takes one decoded instruction per handshake and
 answers one cycle later with branch, link, status, stack and fault pulses; table branches branch after the table read.
 Assumes a decoder supplies register values and a memory port serves table reads.
*/
`timescale 1ns/100ps
module bce_exec #(
    parameter logic [31:0] RET_MARKER = 32'hffff_fff0,
    parameter logic [31:0] PSW_PART_MASK = 32'h0000_01ff
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic ins_valid,
    output logic ins_ready,
    input wire bce_pkg::bce_op_e ins_op,
    input wire logic ins_wide,
    input wire logic [31:0] ins_pc,
    input wire logic [31:0] ins_imm,
    input wire logic [3:0] ins_cond,
    input wire logic [2:0] ins_it_sw,
    input wire logic [1:0] ins_it_len,
    input wire logic [31:0] src_val,
    input wire logic [3:0] opnd_idx,
    input wire logic [31:0] base_val,
    input wire logic base_is_pc,
    input wire logic [3:0] flags,
    input wire logic secure,
    input wire logic [31:0] psw_in,
    output logic tbl_req,
    output logic tbl_half,
    output logic [31:0] tbl_addr,
    input wire logic tbl_ack,
    input wire logic [15:0] tbl_data,
    input wire logic exc_take,
    input wire logic exc_return,
    input wire logic [bce_pkg::IT_SAVE_W-1:0] it_restore,
    output logic [bce_pkg::IT_SAVE_W-1:0] it_save,
    output logic it_active,
    output logic ins_done,
    output logic ins_exec,
    output logic br_valid,
    output logic [31:0] br_target,
    output logic lr_we,
    output logic [3:0] lr_idx,
    output logic [31:0] lr_data,
    output logic thumb_we,
    output logic thumb_bit,
    output logic ns_switch,
    output logic push_valid,
    output logic [31:0] push_ret,
    output logic [31:0] push_psw,
    output logic usage_fault,
    output logic breakpoint_instruction_hit,
    output logic flag_we
);
    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    typedef struct packed {
        bce_pkg::bce_state_e st;
        logic done;
        logic exec;
        logic br;
        logic [31:0] tgt;
        logic lr_we;
        logic [31:0] lr;
        logic th_we;
        logic th;
        logic ns;
        logic push;
        logic [31:0] pret;
        logic [31:0] ppsw;
        logic fault;
        logic breakpoint_instruction;
        logic treq;
        logic thalf;
        logic [31:0] taddr;
        logic [31:0] tnext;
    } bce_exec_s;
    bce_exec_s s_ff, nxt_s;

    logic acc, it_last, pass, pass_eff, range_ok, cb_ok, pc_writer;
    logic it_start, it_step;
    logic [3:0] it_cond, eff_cond;
    logic [31:0] nxt_ins, label_tgt, reg_tgt, tb_off, tb_base;
    logic signed [31:0] lo, hi, cb_rel;

    // ---------------------------------------------------------------
    // Condition and address arithmetic
    // ---------------------------------------------------------------
    assign acc = ins_valid && ins_ready;
    assign ins_ready = (s_ff.st == bce_pkg::ST_IDLE);
    // Only the conditional branch carries a condition outside a block
    assign eff_cond = it_active ? it_cond : (ins_op == bce_pkg::OP_B_COND ? ins_cond : bce_pkg::COND_AL);
    assign pass_eff = pass || (ins_op == bce_pkg::OP_BREAKPOINT_INSTRUCTION);
    assign nxt_ins = ins_pc + (ins_wide ? bce_pkg::WIDE_LEN : bce_pkg::NARROW_LEN);
    assign label_tgt = ins_pc + bce_pkg::PC_AHEAD + ins_imm;
    assign reg_tgt = {src_val[31:1], 1'b0};
    assign cb_rel = $signed(label_tgt - ins_pc);
    assign cb_ok = (cb_rel >= bce_pkg::CB_MIN) && (cb_rel <= bce_pkg::CB_MAX)
        && (opnd_idx <= bce_pkg::LOW_REG_MAX);
    assign tb_base = base_is_pc ? nxt_ins : base_val;
    assign tb_off = s_ff.thalf ? {15'h0000, tbl_data, 1'b0} : {24'h000000, tbl_data[7:0]};
    assign pc_writer = (ins_op inside {bce_pkg::OP_B, bce_pkg::OP_B_COND, bce_pkg::OP_BL,
        bce_pkg::OP_REG_BR, bce_pkg::OP_REG_BR_LINK, bce_pkg::OP_NS_BR, bce_pkg::OP_NS_BR_LINK,
        bce_pkg::OP_TB_BYTE, bce_pkg::OP_TB_HALF});

    // Reach of label branches; conditional form widens inside a block
    always_comb begin
        case (ins_op)
            bce_pkg::OP_B: begin
                lo = bce_pkg::B_MIN;
                hi = bce_pkg::B_MAX;
            end
            bce_pkg::OP_B_COND: begin
                lo = it_active ? bce_pkg::B_MIN : bce_pkg::BC_MIN;
                hi = it_active ? bce_pkg::B_MAX : bce_pkg::BC_MAX;
            end
            default: begin
                lo = bce_pkg::BL_MIN;
                hi = bce_pkg::BL_MAX;
            end
        endcase
        range_ok = ($signed(ins_imm) >= lo) && ($signed(ins_imm) <= hi);
    end

    // ---------------------------------------------------------------
    // Instruction execution
    // ---------------------------------------------------------------
    always_comb begin
        nxt_s = s_ff;
        nxt_s.done = 1'b0;
        nxt_s.exec = 1'b0;
        nxt_s.br = 1'b0;
        nxt_s.lr_we = 1'b0;
        nxt_s.th_we = 1'b0;
        nxt_s.ns = 1'b0;
        nxt_s.push = 1'b0;
        nxt_s.fault = 1'b0;
        nxt_s.breakpoint_instruction = 1'b0;
        it_start = 1'b0;
        case (s_ff.st)
            bce_pkg::ST_IDLE: begin
                if (acc && !exc_take) begin
                    nxt_s.done = 1'b1;
                    nxt_s.exec = pass_eff;
                    if (!pass_eff) begin
                        nxt_s.exec = 1'b0;
                    end else if (it_active && pc_writer && !it_last) begin
                        nxt_s.fault = 1'b1;
                    end else begin
                        case (ins_op)
                            bce_pkg::OP_B, bce_pkg::OP_B_COND, bce_pkg::OP_BL: begin
                                if (!range_ok) begin
                                    nxt_s.fault = 1'b1;
                                end else begin
                                    nxt_s.br = 1'b1;
                                    nxt_s.tgt = label_tgt;
                                    nxt_s.lr_we = (ins_op == bce_pkg::OP_BL);
                                    nxt_s.lr = {nxt_ins[31:1], 1'b1};
                                end
                            end
                            bce_pkg::OP_REG_BR, bce_pkg::OP_REG_BR_LINK: begin
                                nxt_s.th_we = 1'b1;
                                nxt_s.th = src_val[0];
                                if (!src_val[0]) begin
                                    nxt_s.fault = 1'b1;
                                end else begin
                                    nxt_s.br = 1'b1;
                                    nxt_s.tgt = reg_tgt;
                                    nxt_s.lr_we = (ins_op == bce_pkg::OP_REG_BR_LINK);
                                    nxt_s.lr = {nxt_ins[31:1], 1'b1};
                                end
                            end
                            bce_pkg::OP_NS_BR, bce_pkg::OP_NS_BR_LINK: begin
                                if (!secure) begin
                                    nxt_s.fault = 1'b1;
                                end else begin
                                    nxt_s.br = 1'b1;
                                    nxt_s.tgt = reg_tgt;
                                    nxt_s.ns = !src_val[0];
                                    nxt_s.lr = {nxt_ins[31:1], 1'b1};
                                    nxt_s.lr_we = (ins_op == bce_pkg::OP_NS_BR_LINK);
                                    if (ins_op == bce_pkg::OP_NS_BR_LINK && !src_val[0]) begin
                                        nxt_s.push = 1'b1;
                                        nxt_s.pret = {nxt_ins[31:1], 1'b1};
                                        nxt_s.ppsw = psw_in & PSW_PART_MASK;
                                        nxt_s.lr = RET_MARKER;
                                    end
                                end
                            end
                            bce_pkg::OP_CB_ZERO, bce_pkg::OP_CB_NONZERO: begin
                                if (it_active || !cb_ok) begin
                                    nxt_s.fault = 1'b1;
                                end else if ((src_val == 32'h0) == (ins_op == bce_pkg::OP_CB_ZERO)) begin
                                    nxt_s.br = 1'b1;
                                    nxt_s.tgt = label_tgt;
                                end
                            end
                            bce_pkg::OP_IT: begin
                                if (it_active) begin
                                    nxt_s.fault = 1'b1;
                                end else if (ins_cond == bce_pkg::COND_AL && ins_it_sw != 3'h0) begin
                                    nxt_s.fault = 1'b1;
                                end else begin
                                    it_start = 1'b1;
                                end
                            end
                            bce_pkg::OP_TB_BYTE, bce_pkg::OP_TB_HALF: begin
                                nxt_s.st = bce_pkg::ST_TBL;
                                nxt_s.treq = 1'b1;
                                nxt_s.thalf = (ins_op == bce_pkg::OP_TB_HALF);
                                nxt_s.taddr = tb_base + (nxt_s.thalf ? {src_val[30:0], 1'b0} : src_val);
                                nxt_s.tnext = nxt_ins;
                            end
                            bce_pkg::OP_BREAKPOINT_INSTRUCTION: begin
                                nxt_s.breakpoint_instruction = 1'b1;
                            end
                            bce_pkg::OP_IRQ_MASK: begin
                                nxt_s.fault = it_active;
                            end
                            default: begin
                                nxt_s.exec = pass_eff;
                            end
                        endcase
                    end
                end
            end
            bce_pkg::ST_TBL: begin
                if (exc_take) begin
                    nxt_s.st = bce_pkg::ST_IDLE;
                    nxt_s.treq = 1'b0;
                end else if (tbl_ack) begin
                    nxt_s.st = bce_pkg::ST_IDLE;
                    nxt_s.treq = 1'b0;
                    nxt_s.br = 1'b1;
                    nxt_s.tgt = s_ff.tnext + tb_off;
                end
            end
            default: begin
                nxt_s.st = bce_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            s_ff <= '0;
            s_ff.st <= bce_pkg::ST_IDLE;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // Every instruction taken inside a block uses up one slot
    assign it_step = acc && !exc_take && it_active;

    bce_cond u_cond (
        .cond(eff_cond),
        .flags(flags),
        .pass(pass)
    );

    bce_itstate u_it (
        .mclk(mclk),
        .nrst(nrst),
        .start(it_start),
        .start_cond(ins_cond),
        .start_sw(ins_it_sw),
        .start_len(ins_it_len),
        .step(it_step),
        .exc_take(exc_take),
        .exc_return(exc_return),
        .restore_val(it_restore),
        .active(it_active),
        .last(it_last),
        .cur_cond(it_cond),
        .save_val(it_save)
    );

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign ins_done = s_ff.done;
    assign ins_exec = s_ff.exec;
    assign br_valid = s_ff.br;
    assign br_target = s_ff.tgt;
    assign lr_we = s_ff.lr_we;
    assign lr_idx = bce_pkg::LINK_REG_IDX;
    assign lr_data = s_ff.lr;
    assign thumb_we = s_ff.th_we;
    assign thumb_bit = s_ff.th;
    assign ns_switch = s_ff.ns;
    assign push_valid = s_ff.push;
    assign push_ret = s_ff.pret;
    assign push_psw = s_ff.ppsw;
    assign usage_fault = s_ff.fault;
    assign breakpoint_instruction_hit = s_ff.breakpoint_instruction;
    assign tbl_req = s_ff.treq;
    assign tbl_half = s_ff.thalf;
    assign tbl_addr = s_ff.taddr;
    assign flag_we = 1'b0;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    logic go;
    assign go = acc && !exc_take && pass_eff && !(it_active && pc_writer && !it_last);

    AST_LINK_ODD: assert property (lr_we && !push_valid |-> lr_data[0] && lr_idx == 4'he)
        else $error("link value without bit 0 set");
    AST_BX_FAULT: assert property (go && ins_op == bce_pkg::OP_REG_BR && !src_val[0]
        |=> usage_fault && !br_valid && thumb_we && !thumb_bit)
        else $error("register branch with even target did not fault");
    AST_BLX_LINK: assert property (go && ins_op == bce_pkg::OP_REG_BR_LINK && src_val[0]
        |=> br_valid && br_target == {$past(src_val[31:1]), 1'b0} && lr_data == ($past(nxt_ins) | 32'h1))
        else $error("linked register branch target or link wrong");
    AST_NS_UNDEF: assert property (go && ins_op inside {bce_pkg::OP_NS_BR, bce_pkg::OP_NS_BR_LINK} && !secure
        |=> usage_fault && !ns_switch && !br_valid)
        else $error("non-secure branch executed in non-secure state");
    AST_NS_CALL: assert property (go && ins_op == bce_pkg::OP_NS_BR_LINK && secure && !src_val[0]
        |=> ns_switch && push_valid && lr_data == RET_MARKER)
        else $error("state change call did not push or load marker");
    AST_NS_STAY: assert property (go && ins_op == bce_pkg::OP_NS_BR && secure && src_val[0] |=> !ns_switch)
        else $error("state changed with odd target");
    AST_COND_RANGE: assert property (go && ins_op == bce_pkg::OP_B_COND && !it_active
        && $signed(ins_imm) > 32'sd254 |=> usage_fault && !br_valid)
        else $error("conditional branch beyond reach was taken");
    AST_CB_ZERO: assert property (go && ins_op == bce_pkg::OP_CB_ZERO && cb_ok && !it_active && src_val == 32'h0
        |=> br_valid && br_target == $past(label_tgt))
        else $error("compare branch on zero did not branch");
    AST_TBL_TGT: assert property (s_ff.st == bce_pkg::ST_TBL && tbl_ack && !exc_take
        |=> br_valid && br_target == s_ff.tnext + $past(tb_off))
        else $error("table branch target wrong");
    AST_BREAKPOINT_INSTRUCTION: assert property (acc && !exc_take && ins_op == bce_pkg::OP_BREAKPOINT_INSTRUCTION && (!it_active || it_last)
        |=> breakpoint_instruction_hit)
        else $error("breakpoint skipped");
    AST_IT_LEN: assert property (it_start && !exc_return |=> it_active && it_save[1:0] == $past(ins_it_len))
        else $error("block length wrong");
    AST_IT_FOUR: assert property (it_start && ins_it_len == bce_pkg::IT_MAX_LEN |=> it_active)
        else $error("block did not open");

    COV_BL: cover property (go && ins_op == bce_pkg::OP_BL ##1 br_valid);
    COV_TBH: cover property (s_ff.st == bce_pkg::ST_TBL && s_ff.thalf && tbl_ack ##1 br_valid);
    COV_NS_CALL: cover property (push_valid && ns_switch);
    COV_IT_EXC: cover property (it_active && exc_take);
endmodule

//--- test/bce_tbl_mem.sv
/*
 Table memory model answering the executor's table read port.
 Assumes tbl_req stays high until the cycle after tbl_ack.
*/
`timescale 1ns/100ps
module bce_tbl_mem (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic tbl_req,
    input wire logic [31:0] tbl_addr,
    output logic tbl_ack,
    output logic [15:0] tbl_data
);
    logic [1:0] wait_ff;
    logic done_ff;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wait_ff <= 2'h0;
            done_ff <= 1'b0;
            tbl_ack <= 1'b0;
            tbl_data <= 16'h0000;
        end else begin
            tbl_ack <= 1'b0;
            // Stale data toggles so no old value passes for an answer
            tbl_data <= ~tbl_data;
            if (!tbl_req) begin
                wait_ff <= 2'h0;
                done_ff <= 1'b0;
            end else if (!done_ff) begin
                wait_ff <= wait_ff + 2'h1;
                if (wait_ff == 2'h2) begin
                    tbl_ack <= 1'b1;
                    done_ff <= 1'b1;
                    tbl_data <= tbl_addr[15:0] + 16'h0010;
                end
            end
        end
    end
endmodule

//--- test/branch_control_exec_tb_top.sv
/*
 Self-checking bench of the branch and control executor.
 Assumes the table memory model serves table reads after a short wait.
*/
`timescale 1ns/100ps
module branch_control_exec_tb_top;
    logic mclk, nrst, ins_valid, ins_ready, ins_wide, base_is_pc, secure, tbl_req, tbl_half, tbl_ack, it_active;
    logic ins_done, ins_exec, br_valid, lr_we, thumb_we, thumb_bit, ns_switch, push_valid, usage_fault, breakpoint_instruction_hit;
    logic flag_we, exc_take, exc_return;
    bce_pkg::bce_op_e ins_op;
    logic [31:0] ins_pc, ins_imm, src_val, base_val, psw_in, tbl_addr, br_target, lr_data, push_ret, push_psw, ta;
    logic [3:0] ins_cond, opnd_idx, flags, lr_idx;
    logic [2:0] ins_it_sw;
    logic [1:0] ins_it_len;
    logic [15:0] tbl_data;
    logic [bce_pkg::IT_SAVE_W-1:0] it_save, it_keep;
    int fail_count, n_checks;
    bce_exec dut_u (.mclk, .nrst, .ins_valid, .ins_ready, .ins_op, .ins_wide, .ins_pc, .ins_imm, .ins_cond,
        .ins_it_sw, .ins_it_len, .src_val, .opnd_idx, .base_val, .base_is_pc, .flags, .secure, .psw_in, .tbl_req,
        .tbl_half, .tbl_addr, .tbl_ack, .tbl_data, .exc_take, .exc_return, .it_restore(it_keep), .it_save,
        .it_active, .ins_done, .ins_exec, .br_valid, .br_target, .lr_we, .lr_idx, .lr_data, .thumb_we, .thumb_bit,
        .ns_switch, .push_valid, .push_ret, .push_psw, .usage_fault, .breakpoint_instruction_hit, .flag_we);
    bce_tbl_mem mem_u (.mclk, .nrst, .tbl_req, .tbl_addr, .tbl_ack, .tbl_data);
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic go(bce_pkg::bce_op_e op, logic [31:0] pc, logic [31:0] imm, logic [31:0] src);
        @(posedge mclk);
        #1;
        ins_op = op;
        ins_pc = pc;
        ins_imm = imm;
        src_val = src;
        ins_valid = 1'b1;
        @(posedge mclk);
        #1;
        ins_valid = 1'b0;
    endtask
    task automatic t_direct;
        go(bce_pkg::OP_B, 32'h0000_0100, 32'h0000_0010, 32'h0);
        chk("b_target", 32'h0000_0114, br_target);
        chk("flag_we", 32'h0, {31'h0, flag_we});
        ins_wide = 1'b1;
        go(bce_pkg::OP_BL, 32'h0000_0200, 32'hffff_fff8, 32'h0);
        chk("bl_target", 32'h0000_01fc, br_target);
        chk("bl_link", 32'hf000_0205, {lr_we, lr_idx, lr_data[26:0]});
        ins_wide = 1'b0;
    endtask
    task automatic t_reg;
        go(bce_pkg::OP_REG_BR, 32'h0, 32'h0, 32'h0000_0301);
        chk("rb", 32'he000_0300, {br_valid, thumb_we, thumb_bit, usage_fault, br_target[27:0]});
        go(bce_pkg::OP_REG_BR_LINK, 32'h0, 32'h0, 32'h0000_0300);
        chk("rb_fault", 32'h1, {30'h0, br_valid, usage_fault});
        go(bce_pkg::OP_NS_BR_LINK, 32'h0000_0040, 32'h0, 32'h0000_0400);
        chk("ns_sw", 32'h7, {29'h0, ns_switch, push_valid, br_valid});
        chk("ns_ret", 32'h43, push_ret);
        chk("ns_lr", 32'hffff_fff0, lr_data);
        chk("ns_psw", psw_in & 32'h0000_01ff, push_psw);
        secure = 1'b0;
        go(bce_pkg::OP_NS_BR, 32'h0, 32'h0, 32'h0000_0400);
        chk("ns_undef", 32'h1, {29'h0, ns_switch, br_valid, usage_fault});
        secure = 1'b1;
    endtask
    task automatic t_cmp;
        go(bce_pkg::OP_CB_ZERO, 32'h0000_0500, 32'h0000_0010, 32'h0);
        chk("cbz", 32'h2000_0514, {2'h0, br_valid, usage_fault, br_target[27:0]});
        go(bce_pkg::OP_CB_NONZERO, 32'h0000_0500, 32'h0000_007e, 32'h5);
        chk("compare_branch_on_nonzero_max", 32'h2000_0582, {2'h0, br_valid, usage_fault, br_target[27:0]});
        opnd_idx = 4'h8;
        go(bce_pkg::OP_CB_NONZERO, 32'h0000_0500, 32'h0000_0010, 32'h5);
        chk("cb_hireg", 32'h1, {30'h0, br_valid, usage_fault});
        go(bce_pkg::OP_B_COND, 32'h0000_0600, 32'h0000_00fe, 32'h0);
        chk("bc_254", 32'h2, {30'h0, br_valid, usage_fault});
        go(bce_pkg::OP_B_COND, 32'h0000_0600, 32'h0000_0100, 32'h0);
        chk("bc_256", 32'h1, {30'h0, br_valid, usage_fault});
    endtask
    task automatic t_block;
        ins_it_sw = 3'h6;
        ins_it_len = 2'h3;
        go(bce_pkg::OP_IT, 32'h0, 32'h0, 32'h0);
        it_keep = it_save;
        exc_take = 1'b1;
        @(posedge mclk);
        #1;
        chk("it_exc", 32'h0, {21'h0, it_save});
        exc_take = 1'b0;
        exc_return = 1'b1;
        @(posedge mclk);
        #1;
        exc_return = 1'b0;
        chk("it_save", 32'h41b, {21'h0, it_save});
        go(bce_pkg::OP_OTHER, 32'h0, 32'h0, 32'h0);
        chk("it_then", 32'h7, {29'h0, ins_done, ins_exec, it_active});
        go(bce_pkg::OP_OTHER, 32'h0, 32'h0, 32'h0);
        chk("it_else", 32'ha, {28'h0, ins_done, ins_exec, it_active, flag_we});
        go(bce_pkg::OP_BREAKPOINT_INSTRUCTION, 32'h0, 32'h0, 32'h0);
        chk("it_breakpoint_instruction", 32'h7, {29'h0, ins_done, ins_exec, breakpoint_instruction_hit});
        go(bce_pkg::OP_B, 32'h800, 32'h10, 32'h0);
        chk("it_last", 32'hd, {28'h0, ins_done, ins_exec, it_active, br_valid});
    endtask
    task automatic t_table;
        ins_wide = 1'b1;
        for (int k = 0; k < 2; k++) begin
            base_is_pc = k[0];
            go(bce_pkg::bce_op_e'(k ? bce_pkg::OP_TB_BYTE : bce_pkg::OP_TB_HALF), 32'h0000_0700, 32'h0, 32'h3);
            ta = k ? 32'h0000_0707 : base_val + 32'h6;
            chk("tbl_addr", ta, tbl_addr);
            chk("tbl_port", k ? 32'h4 : 32'h6, {29'h0, tbl_req, tbl_half, ins_ready});
            repeat (8) if (br_valid !== 1'b1) begin
                @(posedge mclk);
                #1;
            end
            chk("tb_target", 32'h0000_0704 + (k ? ((ta + 32'h10) & 32'hff) : (ta[15:0] + 16'h10) * 2), br_target);
        end
        ins_wide = 1'b0;
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        {nrst, ins_valid, ins_wide, base_is_pc, ins_it_sw, ins_it_len, ins_imm, src_val, ins_pc} = '0;
        {exc_take, exc_return, it_keep} = '0;
        {secure, flags, ins_cond, opnd_idx, base_val, psw_in} = {1'b1, 4'h4, 4'h0, 4'h3, 32'h2000, 32'h8765_4321};
        ins_op = bce_pkg::OP_OTHER;
        repeat (3) @(posedge mclk);
        #1;
        nrst = 1'b1;
        t_direct;
        t_reg;
        t_block;
        t_table;
        t_cmp;
        print_verdict;
    end
    initial begin
        #5000;
        fail_count++;
        print_verdict;
    end
endmodule
